//--- mjc_regs.vh
`ifndef MJC_REGS_VH
`define MJC_REGS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define MJC_CTRL_ADDR 8'h00
`define MJC_STAT_ADDR 8'h04
`define MJC_LOOP_ADDR 8'h08
`define MJC_ID_ADDR 8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MJC_CTRL_OVR_BIT 0
`define MJC_CTRL_LED_BIT 1
`define MJC_CTRL_LOOPEN_BIT 2
`define MJC_STAT_SWITCH_BIT 0
`define MJC_STAT_PORTEN_BIT 1
`define MJC_STAT_CFGLED_BIT 2
`define MJC_STAT_LOOPIN_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MJC_CTRL_RST 3'h0
`define MJC_LOOP_DIV_RST 16'h0001
// Identification value is arbitrary
`define MJC_ID_VALUE 32'h4d4a4301

// ----------------------------------------
// Timing
// ----------------------------------------
`define MJC_CLK_MHZ 40
`define MJC_XTAL_KHZ 32000
`define MJC_XTAL_PPM 50

// AXI response codes
`define MJC_RESP_OKAY 2'h0
`define MJC_RESP_SLVERR 2'h2

`endif

//--- mjc_mode_ctrl.v
// Summary of operation
// - Switch to computer side enables programming port
// - Switch to user side: enable net low unless override is set
// - Enable net is switch OR override
// - Floating or high override keeps port enabled
// - Sense reads one when port enabled
// - Config lamp lit only in configuration mode
// - User lamp driven freely by design
// - Crystal clock feeds synchronous logic
// - Clock loop output returns to global input
`timescale 1ns/1ps
`include "mjc_regs.vh"

module mjc_mode_ctrl (
	ref_clk,
	rst_b,
	switch_cfg,
	ovr_o,
	ovr_oe,
	port_en,
	sense_in,
	cfg_led,
	user_led,
	loop_out,
	loop_in,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready
);
	input wire ref_clk;
	input wire rst_b;
	input wire switch_cfg;
	output wire ovr_o;
	output wire ovr_oe;
	output wire port_en;
	input wire sense_in;
	output wire cfg_led;
	output reg user_led;
	output reg loop_out;
	input wire loop_in;
	input wire [7:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [7:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	reg [2:0] ctrl_q;
	reg [15:0] div_q;
	reg [15:0] div_cnt_q;
	reg [7:0] aw_q;
	reg aw_have_q;
	reg [31:0] w_q;
	reg [3:0] ws_q;
	reg w_have_q;

	// Override is open drain: drive low to release the port, else float
	// so the pull-up holds the port enabled.
	assign ovr_o = 1'b0;
	assign ovr_oe = ~ctrl_q[`MJC_CTRL_OVR_BIT];

	// Board-level OR of switch and override, as the pull-up resolves it.
	assign port_en = switch_cfg | ~ovr_oe;
	assign cfg_led = switch_cfg;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Third stage lets a change count only when stages two and three agree.
	reg [2:0] sense_sync_q;
	reg [2:0] loop_sync_q;
	reg sense_q;
	reg loop_q;
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sense_sync_q <= 3'h0;
			loop_sync_q <= 3'h0;
			sense_q <= 1'b0;
			loop_q <= 1'b0;
		end else begin
			sense_sync_q <= {sense_sync_q[1:0], sense_in};
			loop_sync_q <= {loop_sync_q[1:0], loop_in};
			if (sense_sync_q[1] == sense_sync_q[2]) begin
				sense_q <= sense_sync_q[2];
			end
			if (loop_sync_q[1] == loop_sync_q[2]) begin
				loop_q <= loop_sync_q[2];
			end
		end
	end

	// ----------------------------------------
	// Clock loop divider
	// ----------------------------------------
	// Loop output toggles every div_q+1 cycles; the returned copy is only
	// sampled here, since this block keeps a single clock.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_q <= 16'h0000;
			loop_out <= 1'b0;
		end else if (!ctrl_q[`MJC_CTRL_LOOPEN_BIT]) begin
			div_cnt_q <= 16'h0000;
			loop_out <= 1'b0;
		end else if (div_cnt_q >= div_q) begin
			div_cnt_q <= 16'h0000;
			loop_out <= ~loop_out;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// AXI4-Lite write
	// ----------------------------------------
	assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_q <= 8'h00;
			aw_have_q <= 1'b0;
			w_q <= 32'h00000000;
			ws_q <= 4'h0;
			w_have_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			ctrl_q <= `MJC_CTRL_RST;
			div_q <= `MJC_LOOP_DIV_RST;
			user_led <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end
			if (aw_have_q && w_have_q) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `MJC_RESP_OKAY;
				case (aw_q)
				`MJC_CTRL_ADDR: begin
					if (ws_q[0]) begin
						ctrl_q <= w_q[2:0];
						user_led <= w_q[`MJC_CTRL_LED_BIT];
					end
				end
				`MJC_LOOP_ADDR: begin
					if (ws_q[0]) begin
						div_q[7:0] <= w_q[7:0];
					end
					if (ws_q[1]) begin
						div_q[15:8] <= w_q[15:8];
					end
				end
				`MJC_STAT_ADDR, `MJC_ID_ADDR: begin
					s_axi_bresp <= `MJC_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `MJC_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read
	// ----------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `MJC_RESP_OKAY;
			case (s_axi_araddr)
			`MJC_CTRL_ADDR: begin
				s_axi_rdata <= {29'h0, ctrl_q[2], user_led, ctrl_q[0]};
			end
			`MJC_STAT_ADDR: begin
				s_axi_rdata <= {28'h0, loop_q, cfg_led, port_en, sense_q};
			end
			`MJC_LOOP_ADDR: begin
				s_axi_rdata <= {16'h0000, div_q};
			end
			`MJC_ID_ADDR: begin
				s_axi_rdata <= `MJC_ID_VALUE;
			end
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `MJC_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

//--- mjc_mode_ctrl_chk.sv
`timescale 1ns/1ps
module mjc_chk(
	input wire ref_clk,
	input wire rst_b,
	input wire switch_cfg,
	input wire ovr_oe,
	input wire port_en,
	input wire cfg_led,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	AST_EN_OR: assert property (port_en == (switch_cfg | !ovr_oe))
		else $error("enable net is not switch or override");
	AST_CFG_ON: assert property (switch_cfg |-> port_en && cfg_led)
		else $error("configuration mode not shown");
	AST_USE_OFF: assert property (!switch_cfg && ovr_oe |-> !port_en)
		else $error("enable net high in use mode");
	AST_FLOAT: assert property (!ovr_oe |-> port_en)
		else $error("released override did not enable port");
	AST_LAMP_OFF: assert property ($fell(switch_cfg) |-> !cfg_led)
		else $error("lamp still lit in use mode");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AR_REF: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule
bind mjc_mode_ctrl mjc_chk u_chk(.ref_clk(ref_clk), .rst_b(rst_b),
	.switch_cfg(switch_cfg), .ovr_oe(ovr_oe), .port_en(port_en),
	.cfg_led(cfg_led), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

//--- mjc_brd_mdl.sv
`timescale 1ns/1ps
module mjc_brd_mdl(
	input wire sw_sel,
	input wire port_en,
	input wire loop_out,
	output wire switch_cfg,
	output wire sense_in,
	output wire loop_in
);
	assign switch_cfg = sw_sel;
	// Sense pin follows the enable net, never driven by the design
	assign sense_in = port_en;
	assign loop_in = loop_out;
endmodule

//--- mjc_tb.sv
`timescale 1ns/1ps
`include "mjc_regs.vh"
module tb;
	logic ref_clk = 0, rst_b = 0, sw_sel = 0, lo;
	logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	wire awr, wrdy, bv, arr, rv, ovr_o, ovr_oe, port_en, sense_in;
	wire cfg_led, user_led, loop_out, loop_in, switch_cfg;
	wire [1:0] brs, rrs;
	wire [31:0] rdt;
	int mismatches = 0, cmp_count = 0, n;
	mjc_mode_ctrl uut(.ref_clk(ref_clk), .rst_b(rst_b),
		.switch_cfg(switch_cfg), .ovr_o(ovr_o), .ovr_oe(ovr_oe),
		.port_en(port_en), .sense_in(sense_in), .cfg_led(cfg_led),
		.user_led(user_led), .loop_out(loop_out), .loop_in(loop_in),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(brs), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs),
		.s_axi_rvalid(rv), .s_axi_rready(rry));
	mjc_brd_mdl u_brd(.sw_sel(sw_sel), .port_en(port_en),
		.loop_out(loop_out), .switch_cfg(switch_cfg),
		.sense_in(sense_in), .loop_in(loop_in));
	always #12.5 ref_clk = ~ref_clk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_pend, w_pend;
		aw_pend = 1;
		w_pend = 1;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		// Each channel is released only at its own handshake edge
		while (aw_pend || w_pend) begin
			@(posedge ref_clk);
			if (aw_pend && awr) begin
				aw_pend = 0;
				awv <= 0;
			end
			if (w_pend && wrdy) begin
				w_pend = 0;
				wv <= 0;
			end
		end
		do @(posedge ref_clk); while (!bv);
		chk(brs, `MJC_RESP_OKAY);
		bry <= 0;
		// Let an edge pass so a following call may raise bready again
		@(posedge ref_clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do @(posedge ref_clk); while (!arr);
		arv <= 0;
		while (!rv) @(posedge ref_clk);
		chk(rdt, e);
		chk(rrs, r);
		rry <= 0;
		@(posedge ref_clk);
	endtask
	task stop_test;
		if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100us;
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1;
		@(posedge ref_clk);
		chk({ovr_oe, ovr_o}, 2'b10);
		rd(`MJC_CTRL_ADDR, 0, 0);
		sw_sel <= 1;
		rd(`MJC_STAT_ADDR, 32'h6, 0);
		repeat (8) @(posedge ref_clk);
		rd(`MJC_STAT_ADDR, 32'h7, 0);
		sw_sel <= 0;
		repeat (8) @(posedge ref_clk);
		rd(`MJC_STAT_ADDR, 32'h0, 0);
		wr(`MJC_CTRL_ADDR, 32'h1);
		repeat (8) @(posedge ref_clk);
		rd(`MJC_STAT_ADDR, 32'h3, 0);
		wr(`MJC_CTRL_ADDR, 32'h2);
		chk({user_led, port_en}, 2'b10);
		rd(`MJC_ID_ADDR, `MJC_ID_VALUE, 0);
		rd(8'h10, 0, `MJC_RESP_SLVERR);
		wr(`MJC_LOOP_ADDR, 32'h2);
		wr(`MJC_CTRL_ADDR, 32'h4);
		n = 0;
		lo = loop_out;
		repeat (30) begin
			@(posedge ref_clk);
			if (loop_out !== lo) n++;
			lo = loop_out;
		end
		chk(n >= 9 && n <= 11, 1);
		rd(`MJC_CTRL_ADDR, 32'h4, 0);
		stop_test;
	end
endmodule
